// ===== design/isolated_input_pkg.sv
/*
 * shared constants: register offsets, mode and delay codes, timing
 * figures and power-up states.
 * assumes one 25 MHz clock; times are in nanoseconds.
 */
package isolated_input_pkg;

    // clock period of ref_clk
    localparam int CLK_PERIOD_NS = 40;

    // channel count and field widths
    localparam int NUM_CH = 8;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [2:0] LIVE_CHANNEL_STATE_ADDR = 3'h0;
    localparam logic [2:0] FILTER_MODE_LOW_ADDR = 3'h1;
    localparam logic [2:0] FILTER_MODE_HIGH_ADDR = 3'h2;
    localparam logic [2:0] FILTER_DELAY_LOW_ADDR = 3'h3;
    localparam logic [2:0] FILTER_DELAY_HIGH_ADDR = 3'h4;

    // register reset values: every channel low-pass, no extra delay
    localparam logic [7:0] FILTER_MODE_RESET = 8'h55;
    localparam logic [7:0] FILTER_DELAY_RESET = 8'h00;

    // debounce mode codes (2-bit field per channel)
    localparam logic [1:0] MODE_DEGLITCH = 2'h0;
    localparam logic [1:0] MODE_LOWPASS = 2'h1;
    localparam logic [1:0] MODE_BLANKING = 2'h2;
    localparam logic [1:0] MODE_SPARE = 2'h3;

    // delay codes (2-bit field per channel)
    localparam logic [1:0] DELAY_NONE = 2'h0;
    localparam logic [1:0] DELAY_10MS = 2'h1;
    localparam logic [1:0] DELAY_30MS = 2'h2;
    localparam logic [1:0] DELAY_100MS = 2'h3;

    // extra delays counted in millisecond ticks
    localparam int DLY_CNT_W = 7;
    localparam logic [6:0] TICKS_10MS = 7'h0a;
    localparam logic [6:0] TICKS_30MS = 7'h1e;
    localparam logic [6:0] TICKS_100MS = 7'h64;

    // one millisecond tick, in clock cycles
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;

    // fixed 4 us low-pass stage, least time so rounded up
    localparam int LP_TIME_NS = 4000;
    localparam int LP_CYCLES =
        (LP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LP_CNT_W = 7;
    localparam logic [6:0] LP_MAX = 7'(LP_CYCLES);

    // wait after the supply leaves lockout before outputs are driven
    localparam int STARTUP_WAIT_NS = 40000;
    localparam int STARTUP_CYCLES =
        (STARTUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int START_CNT_W = 10;
    localparam logic [9:0] START_LAST = 10'(STARTUP_CYCLES - 1);

    // power-up sequencing
    typedef enum logic [1:0] {
        ST_LOCKOUT,
        ST_STARTUP,
        ST_CLEAR,
        ST_RUN
    } run_state_e;

endpackage : isolated_input_pkg

// ===== design/channel_filter.sv
/*
 * one slow channel: fixed low-pass integrator, then a debounce stage
 * (deglitch, low-pass or blanking) counted in millisecond ticks.
 * assumes tick is a one-cycle divider enable on the same clock and
 * clear is held while the channel must not track its input.
 */
`timescale 1ns/1ps
module channel_filter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // control
    input wire logic clear,
    input wire logic tick,
    input wire logic [1:0] modeSel,
    input wire logic [1:0] delaySel,
    // data
    input wire logic rawIn,
    output logic filtOut
);

    // all channel state in one record
    typedef struct packed {
        logic [isolated_input_pkg::LP_CNT_W-1:0] lpCnt; // integrator
        logic lpOut; // fixed stage out
        logic [isolated_input_pkg::DLY_CNT_W-1:0] dCnt; // tick counter
        logic out; // filtered level
    } chan_s;

    chan_s q;
    chan_s d;
    logic [isolated_input_pkg::DLY_CNT_W-1:0] limit;

    // delay code to tick count
    always_comb begin
        unique case (delaySel)
            isolated_input_pkg::DELAY_NONE: limit = '0;
            isolated_input_pkg::DELAY_10MS: limit =
                isolated_input_pkg::TICKS_10MS;
            isolated_input_pkg::DELAY_30MS: limit =
                isolated_input_pkg::TICKS_30MS;
            isolated_input_pkg::DELAY_100MS: limit =
                isolated_input_pkg::TICKS_100MS;
        endcase
    end

    // next-state logic for both filter stages
    always_comb begin
        d = q;
        if (clear) begin
            // restart from low so tracking begins from a known level
            d = '0;
        end else begin
            // fixed stage always present, whatever the mode
            if (rawIn && q.lpCnt != isolated_input_pkg::LP_MAX) begin
                d.lpCnt = q.lpCnt + 1'b1;
            end else if (!rawIn && q.lpCnt != '0) begin
                d.lpCnt = q.lpCnt - 1'b1;
            end
            if (q.lpCnt == isolated_input_pkg::LP_MAX) begin
                d.lpOut = 1'b1;
            end else if (q.lpCnt == '0) begin
                d.lpOut = 1'b0;
            end
            // debounce stage, chosen per channel
            if (limit == '0) begin
                // no extra delay: fixed stage only
                d.out = q.lpOut;
                d.dCnt = '0;
            end else begin
                unique case (modeSel)
                    isolated_input_pkg::MODE_DEGLITCH: begin
                        // accept a level only after it held long enough
                        if (q.lpOut == q.out) begin
                            d.dCnt = '0;
                        end else if (tick) begin
                            if (q.dCnt + 1'b1 >= limit) begin
                                d.out = q.lpOut;
                                d.dCnt = '0;
                            end else begin
                                d.dCnt = q.dCnt + 1'b1;
                            end
                        end
                    end
                    isolated_input_pkg::MODE_BLANKING: begin
                        // follow at once, then ignore input for a while
                        if (q.dCnt != '0) begin
                            if (tick) begin
                                d.dCnt = q.dCnt - 1'b1;
                            end
                        end else if (q.lpOut != q.out) begin
                            d.out = q.lpOut;
                            d.dCnt = limit;
                        end
                    end
                    isolated_input_pkg::MODE_LOWPASS,
                    isolated_input_pkg::MODE_SPARE: begin
                        // spare code acts as low-pass, the safe choice
                        if (q.dCnt > limit) begin
                            d.dCnt = limit;
                        end else if (tick) begin
                            if (q.lpOut && q.dCnt != limit) begin
                                d.dCnt = q.dCnt + 1'b1;
                            end else if (!q.lpOut && q.dCnt != '0) begin
                                d.dCnt = q.dCnt - 1'b1;
                            end
                        end
                        if (d.dCnt >= limit) begin
                            d.out = 1'b1;
                        end else if (d.dCnt == '0) begin
                            d.out = 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign filtOut = q.out;

endmodule : channel_filter

// ===== design/isolated_input_debounce.sv
/*
 * eight isolated input channels: fast pass-through or debounce per
 * channel, supply lockout, startup wait, per-channel config registers.
 * assumes inputs and supply comparators are synchronous to ref_clk;
 * serial framing lives outside and reaches us via the register port.
 */
`timescale 1ns/1ps
module isolated_input_debounce #(
    // 1 for the serial variant with registers, 0 for parallel parts
    parameter bit SERIAL_VARIANT = 1'b1,
    // channels wired as fast pass-through, one bit per channel
    parameter logic [7:0] FAST_MASK = 8'h00,
    // delay code shared by all channels on parallel parts
    parameter logic [1:0] PARALLEL_DELAY = 2'h0,
    // clock cycles in one millisecond tick
    parameter int TICK_CYCLES = isolated_input_pkg::TICK_CYCLES_DEF
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // demodulated field inputs
    input wire logic [7:0] fieldChannelIn,
    // supply comparators
    input wire logic supplyAboveEnter,
    input wire logic supplyAboveExit,
    // register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    // serial cascade
    input wire logic serialDataIn,
    output logic serialPassThroughOut,
    // channel outputs
    output logic [7:0] filteredChannelOut,
    output logic [7:0] fastChannelOut,
    output logic outputDriveEn,
    output logic supplyLockout
);

    // tick divider width follows the tick length
    localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // all block state in one record
    typedef struct packed {
        isolated_input_pkg::run_state_e st; // sequencing
        logic [isolated_input_pkg::START_CNT_W-1:0] startCnt; // wait count
        logic lockout; // supply low
        logic [TICK_W-1:0] tickCnt; // divider
        logic tick; // 1 ms pulse
        logic [7:0] modeLo; // ch3..ch0
        logic [7:0] modeHi; // ch7..ch4
        logic [7:0] dlyLo; // ch3..ch0
        logic [7:0] dlyHi; // ch7..ch4
        logic [7:0] rdData; // read answer
        logic [7:0] filtOut; // slow outputs
        logic [7:0] fastOut; // fast outputs
        logic driveEn; // outputs live
        logic passThru; // cascade bit
    } top_s;

    top_s q;
    top_s d;

    // per-channel filter hookup
    logic [15:0] modeAll; // packed mode fields, two bits a channel
    logic [15:0] delayAll; // packed delay fields
    logic [7:0] filterRaw; // outputs of the channel filters
    logic filterClear; // holds filters while not running

    // filters only run once the output sequencing reaches run
    assign filterClear = (q.st != isolated_input_pkg::ST_RUN);

    // choose configuration per variant
    always_comb begin
        if (SERIAL_VARIANT) begin
            // each channel takes its own register fields
            modeAll = {q.modeHi, q.modeLo};
            delayAll = {q.dlyHi, q.dlyLo};
        end else begin
            // fixed per part: low-pass only, one shared delay
            modeAll = {8{isolated_input_pkg::MODE_LOWPASS}};
            delayAll = {8{PARALLEL_DELAY}};
        end
    end

    // one filter per channel; fast channels simply ignore theirs
    for (genvar i = 0; i < isolated_input_pkg::NUM_CH; i++) begin : g_ch
        channel_filter u_filter (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .clear(filterClear),
            .tick(q.tick),
            .modeSel(modeAll[2*i +: 2]),
            .delaySel(delayAll[2*i +: 2]),
            .rawIn(fieldChannelIn[i]),
            .filtOut(filterRaw[i])
        );
    end

    // next-state logic: supply, sequencing, tick, registers, outputs
    always_comb begin
        d = q;

        // lockout with hysteresis: enter low, leave only above upper
        if (!supplyAboveEnter) begin
            d.lockout = 1'b1;
        end else if (supplyAboveExit) begin
            d.lockout = 1'b0;
        end

        // millisecond tick divider, free running
        if (q.tickCnt == TICK_LAST) begin
            d.tickCnt = '0;
            d.tick = 1'b1;
        end else begin
            d.tickCnt = q.tickCnt + 1'b1;
            d.tick = 1'b0;
        end

        // power-up sequencing, needs no host action
        if (q.lockout) begin
            // any lockout throws the sequence back to the start
            d.st = isolated_input_pkg::ST_LOCKOUT;
            d.startCnt = '0;
        end else begin
            unique case (q.st)
                isolated_input_pkg::ST_LOCKOUT: begin
                    d.st = isolated_input_pkg::ST_STARTUP;
                    d.startCnt = '0;
                end
                isolated_input_pkg::ST_STARTUP: begin
                    // supply must stay good for the whole wait
                    if (q.startCnt == isolated_input_pkg::START_LAST) begin
                        d.st = isolated_input_pkg::ST_CLEAR;
                    end else begin
                        d.startCnt = q.startCnt + 1'b1;
                    end
                end
                isolated_input_pkg::ST_CLEAR: begin
                    // one cycle of driven low before tracking
                    d.st = isolated_input_pkg::ST_RUN;
                end
                isolated_input_pkg::ST_RUN: begin
                    d.st = isolated_input_pkg::ST_RUN;
                end
            endcase
        end

        // output stage
        if (q.st == isolated_input_pkg::ST_RUN) begin
            // fast channels straight from the input
            d.fastOut = fieldChannelIn & FAST_MASK;
            // slow channels from their filters
            d.filtOut = filterRaw & ~FAST_MASK;
            d.driveEn = 1'b1;
        end else if (q.st == isolated_input_pkg::ST_CLEAR) begin
            // defined low once the wait is over
            d.fastOut = '0;
            d.filtOut = '0;
            d.driveEn = 1'b1;
        end else begin
            // undefined pins: not driven, inputs not followed
            d.fastOut = '0;
            d.filtOut = '0;
            d.driveEn = 1'b0;
        end

        // register writes; parallel parts have no config registers
        if (regWr && SERIAL_VARIANT) begin
            unique case (regAddr)
                isolated_input_pkg::FILTER_MODE_LOW_ADDR:
                    d.modeLo = regWrData;
                isolated_input_pkg::FILTER_MODE_HIGH_ADDR:
                    d.modeHi = regWrData;
                isolated_input_pkg::FILTER_DELAY_LOW_ADDR:
                    d.dlyLo = regWrData;
                isolated_input_pkg::FILTER_DELAY_HIGH_ADDR:
                    d.dlyHi = regWrData;
                default: begin
                    // read-only or unmapped: the write is dropped
                end
            endcase
        end

        // read answer stands for exactly the cycle after the strobe
        d.rdData = '0;
        if (regRd) begin
            unique case (regAddr)
                isolated_input_pkg::LIVE_CHANNEL_STATE_ADDR:
                    d.rdData = q.filtOut | q.fastOut;
                isolated_input_pkg::FILTER_MODE_LOW_ADDR:
                    d.rdData = SERIAL_VARIANT ? q.modeLo : '0;
                isolated_input_pkg::FILTER_MODE_HIGH_ADDR:
                    d.rdData = SERIAL_VARIANT ? q.modeHi : '0;
                isolated_input_pkg::FILTER_DELAY_LOW_ADDR:
                    d.rdData = SERIAL_VARIANT ? q.dlyLo : '0;
                isolated_input_pkg::FILTER_DELAY_HIGH_ADDR:
                    d.rdData = SERIAL_VARIANT ? q.dlyHi : '0;
                default: begin
                    // unmapped offsets read as zero
                    d.rdData = '0;
                end
            endcase
        end

        // cascade bit: one-cycle retimed copy of the serial input
        d.passThru = serialDataIn;
    end

    // state register; lockout is assumed until the supply is seen good
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.st <= isolated_input_pkg::ST_LOCKOUT;
            q.lockout <= 1'b1;
            q.modeLo <= isolated_input_pkg::FILTER_MODE_RESET;
            q.modeHi <= isolated_input_pkg::FILTER_MODE_RESET;
            q.dlyLo <= isolated_input_pkg::FILTER_DELAY_RESET;
            q.dlyHi <= isolated_input_pkg::FILTER_DELAY_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state record
    assign regRdData = q.rdData;
    assign serialPassThroughOut = q.passThru;
    assign filteredChannelOut = q.filtOut;
    assign fastChannelOut = q.fastOut;
    assign outputDriveEn = q.driveEn;
    assign supplyLockout = q.lockout;

endmodule : isolated_input_debounce

// ===== tb/isolated_input_debounce_assertions.sv
/*
 * port checker for the isolated input conditioning block.
 * assumes one clock domain and the top module's ports only.
 */
`timescale 1ns/1ps
module io_checks #(
    parameter logic [7:0] FAST_MASK = 8'h00
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // watched ports
    input wire logic [7:0] fieldChannelIn,
    input wire logic supplyAboveEnter,
    input wire logic supplyAboveExit,
    input wire logic [2:0] regAddr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic serialDataIn,
    input wire logic serialPassThroughOut,
    input wire logic [7:0] filteredChannelOut,
    input wire logic [7:0] fastChannelOut,
    input wire logic outputDriveEn,
    input wire logic supplyLockout
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // three defined cycles in a row, so the previous one was a run cycle
    sequence runSeen;
        outputDriveEn [*3];
    endsequence
    // supply flagged low, then two cycles on: state first, outputs next
    sequence lockSeen;
        supplyLockout ##2 1'b1;
    endsequence

    rd_idle_zero_a: assert property (
        !$past(regRd) |-> regRdData == 8'h00)
        else $error("read data not zero outside read slot");
    unmapped_rd_zero_a: assert property (
        regRd && regAddr > 3'h4 |=> regRdData == 8'h00)
        else $error("unmapped read returned data");
    pass_through_a: assert property (
        serialPassThroughOut == $past(serialDataIn))
        else $error("pass-through not a one cycle copy");
    lock_enter_a: assert property (
        !supplyAboveEnter |=> supplyLockout)
        else $error("lockout not entered");
    lock_hold_a: assert property (
        supplyLockout && !supplyAboveExit |=> supplyLockout)
        else $error("lockout left below exit level");
    lock_quiet_a: assert property (
        lockSeen |-> !outputDriveEn &&
            (filteredChannelOut | fastChannelOut) == 8'h00)
        else $error("outputs active in lockout");
    clear_low_a: assert property (
        $rose(outputDriveEn) |->
            (filteredChannelOut | fastChannelOut) == 8'h00)
        else $error("outputs not low when first driven");
    fast_track_a: assert property (
        runSeen |-> fastChannelOut == ($past(fieldChannelIn) & FAST_MASK))
        else $error("fast lane does not track input");
    lane_split_a: assert property (
        (filteredChannelOut & FAST_MASK) == 8'h00 &&
            (fastChannelOut & ~FAST_MASK) == 8'h00)
        else $error("channel on the wrong lane");
endmodule : io_checks

bind isolated_input_debounce io_checks #(.FAST_MASK(FAST_MASK)) chk_u (
    .ref_clk, .rstn, .fieldChannelIn, .supplyAboveEnter, .supplyAboveExit,
    .regAddr, .regRd, .regRdData, .serialDataIn, .serialPassThroughOut,
    .filteredChannelOut, .fastChannelOut, .outputDriveEn, .supplyLockout
);

// ===== tb/host_reader.sv
/*
 * host side model: latches the channel outputs while they are defined.
 * assumes the outputs are synchronous to ref_clk.
 */
`timescale 1ns/1ps
module host_reader (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // device outputs
    input wire logic [7:0] slowIn,
    input wire logic [7:0] fastIn,
    input wire logic driveEn,
    // latched view
    output logic [7:0] viewQ
);
    // undetermined lockout levels are never taken, the last good view stays
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            viewQ <= 8'h00;
        end else if (driveEn) begin
            viewQ <= slowIn | fastIn;
        end
    end
endmodule : host_reader

// ===== tb/isolated_input_debounce_tb_top.sv
/*
 * self-checking bench: serial part with four fast lanes beside a
 * parallel part with a fixed 10 tick delay, on shared inputs.
 * assumes a shortened tick of 10 cycles.
 */
`timescale 1ns/1ps
module isolated_input_debounce_tb_top;
    localparam int TICK = 10; // shortened millisecond tick
    localparam int LIMIT = 30000; // cycle ceiling for the whole run
    logic ref_clk, rstn, supplyAboveEnter, supplyAboveExit, regWr, regRd;
    logic serialDataIn, serialPassThroughOut, outputDriveEn, supplyLockout;
    logic [7:0] fieldChannelIn, regWrData, regRdData, parRdData, viewQ;
    logic [7:0] filteredChannelOut, fastChannelOut, parFiltered;
    logic [2:0] regAddr;
    int num_errors, comparisons;
    int cycleCount = 0;

    // serial part, upper four channels fast
    isolated_input_debounce #(.FAST_MASK(8'hf0), .TICK_CYCLES(TICK)) dut_u (
        .ref_clk, .rstn, .fieldChannelIn, .supplyAboveEnter,
        .supplyAboveExit, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .serialDataIn, .serialPassThroughOut, .filteredChannelOut,
        .fastChannelOut, .outputDriveEn, .supplyLockout);
    // parallel part, all slow, low-pass with 10 ticks
    isolated_input_debounce #(.SERIAL_VARIANT(1'b0), .PARALLEL_DELAY(2'h1),
        .TICK_CYCLES(TICK)) par_u (
        .ref_clk, .rstn, .fieldChannelIn, .supplyAboveEnter,
        .supplyAboveExit, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData(parRdData), .serialDataIn, .serialPassThroughOut(),
        .filteredChannelOut(parFiltered), .fastChannelOut(),
        .outputDriveEn(), .supplyLockout());
    host_reader host_u (.ref_clk, .rstn, .slowIn(filteredChannelOut),
        .fastIn(fastChannelOut), .driveEn(outputDriveEn), .viewQ);

    // free running clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // hang guard, counted as a mismatch
    always @(posedge ref_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == LIMIT) begin
            num_errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr

    // data of both parts, taken in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d,
            output logic [7:0] p);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
        p = parRdData;
    endtask : rd

    // reset values, write then read back, read-only and unmapped places
    task automatic test_regs();
        logic [7:0] d, p;
        logic [7:0] rst [8] = '{8'h00, 8'h55, 8'h55, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00};
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), d, p);
            chk(d, rst[a]);
            wr(3'(a), 8'h18 + 8'(a));
        end
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), d, p);
            chk(d, (a >= 1 && a <= 4) ? 8'h18+8'(a) : 8'h00);
            chk(p, 8'h00);
        end
    endtask : test_regs

    // hysteresis, startup wait, outputs low first, then tracking
    task automatic test_powerup();
        int n = 0;
        @(posedge ref_clk);
        fieldChannelIn <= 8'hff;
        supplyAboveEnter <= 1'b1;
        cyc(20);
        #1 chk(8'(supplyLockout), 8'h01);
        @(posedge ref_clk);
        supplyAboveExit <= 1'b1;
        while (outputDriveEn !== 1'b1 && n < 1100) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(8'(n >= 1000 && n <= 1006), 8'h01);
        chk(filteredChannelOut | fastChannelOut, 8'h00);
        cyc(3);
        #1 chk(fastChannelOut, 8'hf0);
        chk(filteredChannelOut, 8'h00);
        fieldChannelIn <= 8'h00;
        cyc(300);
    endtask : test_powerup

    task automatic test_pass();
        logic [3:0] pat = 4'b1011;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            serialDataIn <= pat[i];
            @(posedge ref_clk);
            #1 chk(8'(serialPassThroughOut), 8'(pat[i]));
        end
    endtask : test_pass

    // every delay code on channel 1 in low-pass mode
    task automatic test_delays();
        int ticks [4] = '{0, 10, 30, 100};
        int n, e;
        wr(3'h1, 8'h55);
        for (int c = 0; c < 4; c++) begin
            wr(3'h3, {4'h0, 2'(c), 2'h0});
            e = 100 + ticks[c] * TICK;
            n = 0;
            @(posedge ref_clk);
            fieldChannelIn <= 8'h02;
            while (filteredChannelOut[1] !== 1'b1 && n < e + 200) begin
                @(posedge ref_clk);
                #1 n++;
            end
            chk(8'(n >= e-12 && n <= e+15), 8'h01);
            fieldChannelIn <= 8'h00;
            cyc(e + 150);
            #1 chk(filteredChannelOut, 8'h00);
        end
    endtask : test_delays

    // blanking, low-pass, deglitch and the spare code on one pulse train
    task automatic test_modes();
        wr(3'h1, 8'hc6);
        wr(3'h3, 8'haa);
        for (int p = 0; p < 5; p++) begin
            @(posedge ref_clk);
            fieldChannelIn <= 8'h0f;
            cyc(50);
            if (p == 1) begin
                #1 chk(viewQ & 8'h0f, 8'h01);
                chk(parFiltered & 8'h0f, 8'h0f);
            end
            cyc(100);
            if (p == 0) begin
                #1 chk(viewQ & 8'h0f, 8'h01);
                chk(parFiltered & 8'h0f, 8'h00);
            end
            cyc(50);
            fieldChannelIn <= 8'h00;
            cyc(99);
        end
        cyc(1);
        #1 chk(viewQ & 8'h0e, 8'h0a);
        cyc(1000);
    endtask : test_modes

    // supply drop while running: outputs released, host keeps last view
    task automatic test_lockout();
        logic [7:0] d, p;
        @(posedge ref_clk);
        fieldChannelIn <= 8'hf0;
        cyc(5);
        #1 chk(viewQ, 8'hf0);
        rd(3'h0, d, p);
        chk(d, 8'hf0);
        supplyAboveEnter <= 1'b0;
        supplyAboveExit <= 1'b0;
        cyc(5);
        #1 chk(8'({supplyLockout, outputDriveEn}), 8'h02);
        chk(fastChannelOut | filteredChannelOut, 8'h00);
        chk(viewQ, 8'hf0);
        supplyAboveEnter <= 1'b1;
        cyc(30);
        #1 chk(8'({supplyLockout, fastChannelOut[4]}), 8'h02);
    endtask : test_lockout

    // main sequence
    initial begin
        rstn = 1'b0;
        fieldChannelIn = 8'h00;
        supplyAboveEnter = 1'b0;
        supplyAboveExit = 1'b0;
        regAddr = 3'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        serialDataIn = 1'b0;
        num_errors = 0;
        comparisons = 0;
        cyc(6);
        rstn <= 1'b1;
        test_regs();
        test_powerup();
        test_pass();
        test_delays();
        test_modes();
        test_lockout();
        conclude();
    end
endmodule : isolated_input_debounce_tb_top
